// ===== include/charging_ctrl_pkg.sv
// Shared constants and types for the charging-port mode controller.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
package charging_ctrl_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
    localparam int unsigned PW_IDLE_TIME_S = 15;
    localparam int unsigned PW_IDLE_CYCLES = PW_IDLE_TIME_S * CLK_HZ;
    localparam int unsigned PW_DCHG_TIME_S = 2;
    localparam int unsigned PW_DCHG_CYCLES = PW_DCHG_TIME_S * CLK_HZ;
    localparam int unsigned DCHG_LONG_TIME_MS = 500;
    localparam int unsigned DCHG_LONG_CYCLES = DCHG_LONG_TIME_MS * CLK_PER_MS;
    localparam int unsigned DCHG_SHORT_TIME_MS = 100;
    localparam int unsigned DCHG_SHORT_CYCLES = DCHG_SHORT_TIME_MS * CLK_PER_MS;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam int unsigned CTRL_HID_HOLD_BIT = 0;
    localparam logic CTRL_HID_HOLD_RESET = 1'h1;
    localparam int unsigned ST_MODE_LSB = 0;
    localparam int unsigned ST_DATA_BIT = 4;
    localparam int unsigned ST_LOAD_BIT = 5;
    localparam int unsigned ST_PW_LSB = 6;
    localparam int unsigned ST_DCHG_BIT = 8;
    localparam int unsigned ST_HOLD_BIT = 9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_DISCHARGE,
        MODE_AUTO,
        MODE_AUTO_DETECT,
        MODE_AUTO_PW,
        MODE_DATA_A,
        MODE_DATA_B,
        MODE_CDP,
        MODE_SHORTED,
        MODE_DIVIDER
    } mode_t;

    typedef enum logic [1:0] {
        PH_INIT,
        PH_OFF,
        PH_SWITCH,
        PH_RUN
    } phase_t;

    typedef enum logic [1:0] {
        PW_HIGH,
        PW_LOW,
        PW_DCHG
    } pw_t;

endpackage

// ===== hw/pin_sync.sv
// Two-stage synchroniser for a vector of unrelated pin levels.
// Each bit is independent; no bus coherency is implied.
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb begin
        s_d.meta = async_in;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;

endmodule

// ===== hw/charging_mode_load_detect_ctrl.sv
// Mode decoder, port discharge sequencer and power-wake timer of a
// USB charging-port switch, with an AXI4-Lite register slave.
// Assumes analog comparators and D+/D- monitors deliver async levels.
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module charging_mode_load_detect_ctrl
    import charging_ctrl_pkg::*;
#(
    parameter int unsigned PW_IDLE_CNT = charging_ctrl_pkg::PW_IDLE_CYCLES,
    parameter int unsigned PW_DCHG_CNT = charging_ctrl_pkg::PW_DCHG_CYCLES,
    parameter int unsigned DCHG_LONG_CNT = charging_ctrl_pkg::DCHG_LONG_CYCLES,
    parameter int unsigned DCHG_SHORT_CNT = charging_ctrl_pkg::DCHG_SHORT_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mode_pin_a,
    input wire logic mode_pin_b,
    input wire logic mode_pin_c,
    input wire logic limit_select,
    input wire logic load_above_threshold,
    input wire logic primary_detect_done,
    input wire logic load_below_wake_level,
    input wire logic at_wake_limit,
    input wire logic input_device_seen,
    output charging_ctrl_pkg::mode_t charge_mode,
    output logic port_enable,
    output logic port_discharge,
    output logic data_switch_on,
    output logic sel_high_current_limit,
    output logic sel_low_current_limit,
    output logic sel_power_wake_internal_limit,
    output logic load_present_n
);
    import charging_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (PW_IDLE_CNT < 1 || PW_DCHG_CNT < 1 || DCHG_LONG_CNT < 1 || DCHG_SHORT_CNT < 1) begin
        $error("charging ctrl: every timing count must be at least one cycle");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        phase_t phase;
        mode_t mode;
        pw_t pw;
        logic [2:0] pins;
        logic lim;
        logic [31:0] cnt;
        logic [31:0] dchg_len;
        logic hold;
        logic hid_hold_en;
        logic aw_got;
        logic [11:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic o_en;
        logic o_dchg;
        logic o_data;
        logic o_hi;
        logic o_lo;
        logic o_pw;
        logic o_load_n;
    } ctrl_state_t;

    ctrl_state_t s_q;
    ctrl_state_t s_d;

    logic [8:0] pin_sync_out;
    logic [2:0] pins_now;
    logic lim_now;
    logic load_hi_s;
    logic prim_s;
    logic below_s;
    logic at_lim_s;
    logic hid_s;

    // Pins and analog flags are asynchronous to aclk
    pin_sync #(
        .WIDTH(9)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({input_device_seen, at_wake_limit, load_below_wake_level,
                   primary_detect_done, load_above_threshold, limit_select,
                   mode_pin_a, mode_pin_b, mode_pin_c}),
        .sync_out(pin_sync_out)
    );

    assign pins_now = pin_sync_out[2:0];
    assign lim_now = pin_sync_out[3];
    assign load_hi_s = pin_sync_out[4];
    assign prim_s = pin_sync_out[5];
    assign below_s = pin_sync_out[6];
    assign at_lim_s = pin_sync_out[7];
    assign hid_s = pin_sync_out[8];

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic mode_t decode_mode(input logic [2:0] p, input logic l);
        mode_t m;
        m = MODE_DISCHARGE;
        unique case (p)
            3'h0: m = MODE_DISCHARGE;
            3'h1: m = l ? MODE_AUTO_PW : MODE_AUTO;
            3'h2: m = MODE_DATA_A;
            3'h3: m = l ? MODE_AUTO_DETECT : MODE_AUTO;
            3'h4: m = MODE_SHORTED;
            3'h5: m = MODE_DIVIDER;
            3'h6: m = MODE_DATA_A;
            3'h7: m = l ? MODE_CDP : MODE_DATA_B;
        endcase
        return m;
    endfunction

    function automatic logic is_auto(input mode_t m);
        return m == MODE_AUTO || m == MODE_AUTO_DETECT || m == MODE_AUTO_PW;
    endfunction

    function automatic logic is_data(input mode_t m);
        return m == MODE_DATA_A || m == MODE_DATA_B || m == MODE_CDP;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    mode_t tgt;
    logic hid_block;
    logic need_dchg;
    logic wr_fire;
    logic [31:0] status_word;

    always_comb begin
        s_d = s_q;
        tgt = decode_mode(pins_now, lim_now);
        hid_block = s_q.hid_hold_en && hid_s && pins_now == 3'h3
                    && (s_q.pins == 3'h7 || s_q.pins == 3'h2);
        need_dchg = !(tgt == s_q.mode)
                    && !((s_q.mode == MODE_DATA_B || s_q.mode == MODE_CDP)
                         && (tgt == MODE_DATA_B || tgt == MODE_CDP))
                    && !(is_auto(s_q.mode) && is_auto(tgt))
                    && !(s_q.mode == MODE_DATA_A && tgt == MODE_DATA_A);

        unique case (s_q.phase)
            // initial discharge before pins are trusted
            PH_INIT: begin
                s_d.cnt = s_q.cnt + 32'h1;
                if (s_q.cnt >= 32'(DCHG_SHORT_CNT - 1)) begin
                    s_d.cnt = '0;
                    s_d.mode = tgt;
                    s_d.pins = pins_now;
                    s_d.lim = lim_now;
                    s_d.pw = PW_HIGH;
                    s_d.phase = (tgt == MODE_DISCHARGE) ? PH_OFF : PH_RUN;
                end
            end
            PH_OFF: begin
                s_d.pins = pins_now;
                s_d.lim = lim_now;
                if (tgt != MODE_DISCHARGE) begin
                    s_d.mode = tgt;
                    s_d.pw = PW_HIGH;
                    s_d.cnt = '0;
                    s_d.phase = PH_RUN;
                end
            end
            PH_SWITCH: begin
                s_d.cnt = s_q.cnt + 32'h1;
                if (s_q.cnt >= s_q.dchg_len - 32'h1) begin
                    s_d.cnt = '0;
                    s_d.mode = tgt;
                    s_d.pins = pins_now;
                    s_d.lim = lim_now;
                    s_d.pw = PW_HIGH;
                    s_d.phase = (tgt == MODE_DISCHARGE) ? PH_OFF : PH_RUN;
                end
            end
            PH_RUN: begin
                s_d.hold = hid_block;
                if (tgt == MODE_DISCHARGE) begin
                    s_d.mode = MODE_DISCHARGE;
                    s_d.pins = pins_now;
                    s_d.cnt = '0;
                    s_d.phase = PH_OFF;
                end else if (hid_block) begin
                    s_d.lim = lim_now;
                end else if (need_dchg) begin
                    // long from a data mode into auto, short otherwise
                    s_d.dchg_len = (is_data(s_q.mode) && is_auto(tgt))
                                   ? 32'(DCHG_LONG_CNT) : 32'(DCHG_SHORT_CNT);
                    s_d.cnt = '0;
                    s_d.phase = PH_SWITCH;
                end else begin
                    s_d.mode = tgt;
                    s_d.pins = pins_now;
                    s_d.lim = lim_now;
                    if (tgt == MODE_AUTO_PW && s_q.mode != MODE_AUTO_PW) begin
                        s_d.pw = PW_HIGH;
                        s_d.cnt = '0;
                    end else if (s_q.mode == MODE_AUTO_PW) begin
                        unique case (s_q.pw)
                            PW_HIGH: begin
                                s_d.cnt = below_s ? s_q.cnt + 32'h1 : 32'h0;
                                if (below_s && s_q.cnt >= 32'(PW_IDLE_CNT - 1)) begin
                                    s_d.pw = PW_LOW;
                                    s_d.cnt = '0;
                                end
                            end
                            PW_LOW: begin
                                if (at_lim_s) begin
                                    s_d.pw = PW_DCHG;
                                    s_d.cnt = '0;
                                end
                            end
                            PW_DCHG: begin
                                s_d.cnt = s_q.cnt + 32'h1;
                                if (s_q.cnt >= 32'(PW_DCHG_CNT - 1)) begin
                                    s_d.pw = PW_HIGH;
                                    s_d.cnt = '0;
                                end
                            end
                            default: s_d.pw = PW_HIGH;
                        endcase
                    end
                end
            end
        endcase

        // Outputs follow the next state so they leave flops aligned with it
        s_d.o_en = s_d.phase == PH_RUN && !(s_d.mode == MODE_AUTO_PW && s_d.pw == PW_DCHG);
        s_d.o_dchg = !s_d.o_en;
        s_d.o_data = s_d.o_en && is_data(s_d.mode);
        s_d.o_pw = s_d.o_en && s_d.mode == MODE_AUTO_PW && s_d.pw == PW_LOW;
        s_d.o_lo = s_d.o_en && ((!s_d.lim
                   && (s_d.mode == MODE_DATA_A || s_d.mode == MODE_SHORTED
                       || s_d.mode == MODE_DIVIDER)) || s_d.mode == MODE_DATA_B);
        s_d.o_hi = s_d.o_en && !s_d.o_lo && !s_d.o_pw;
        // inactive high unless a detecting mode
        s_d.o_load_n = 1'b1;
        if (s_d.phase == PH_RUN) begin
            unique case (s_d.mode)
                MODE_CDP: s_d.o_load_n = !(load_hi_s || prim_s);
                MODE_AUTO_DETECT: s_d.o_load_n = !load_hi_s;
                MODE_AUTO_PW: s_d.o_load_n = s_d.pw == PW_LOW;
                default: s_d.o_load_n = 1'b1;
            endcase
        end

        // ------------------------------------------------------------
        // AXI4-Lite slave
        // ------------------------------------------------------------
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb0 = s_axi_wstrb[0];
        end
        wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            if (s_q.awaddr[11:2] == CTRL_OFFSET[11:2]) begin
                if (s_q.wstrb0) begin
                    s_d.hid_hold_en = s_q.wdata[CTRL_HID_HOLD_BIT];
                end
            end else if (s_q.awaddr[11:2] != STATUS_OFFSET[11:2]) begin
                s_d.bresp = RESP_SLVERR;
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        status_word = '0;
        status_word[ST_MODE_LSB +: 4] = s_q.mode;
        status_word[ST_DATA_BIT] = s_q.o_data;
        status_word[ST_LOAD_BIT] = !s_q.o_load_n;
        status_word[ST_PW_LSB +: 2] = s_q.pw;
        status_word[ST_DCHG_BIT] = s_q.o_dchg;
        status_word[ST_HOLD_BIT] = s_q.hold;
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = '0;
            if (s_axi_araddr[11:2] == CTRL_OFFSET[11:2]) begin
                s_d.rdata[CTRL_HID_HOLD_BIT] = s_q.hid_hold_en;
            end else if (s_axi_araddr[11:2] == STATUS_OFFSET[11:2]) begin
                s_d.rdata = status_word;
            end else begin
                s_d.rresp = RESP_SLVERR;
            end
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // reset lands in discharging initial state
            s_q <= '0;
            s_q.phase <= PH_INIT;
            s_q.mode <= MODE_DISCHARGE;
            s_q.pw <= PW_HIGH;
            s_q.dchg_len <= 32'(DCHG_SHORT_CNT);
            s_q.hid_hold_en <= CTRL_HID_HOLD_RESET;
            s_q.o_dchg <= 1'b1;
            s_q.o_load_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // One write in flight; address and data may arrive in either order
    assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    assign charge_mode = s_q.mode;
    assign port_enable = s_q.o_en;
    assign port_discharge = s_q.o_dchg;
    assign data_switch_on = s_q.o_data;
    assign sel_high_current_limit = s_q.o_hi;
    assign sel_low_current_limit = s_q.o_lo;
    assign sel_power_wake_internal_limit = s_q.o_pw;
    assign load_present_n = s_q.o_load_n;

endmodule

// ===== bench/charging_ctrl_assertions.sv
// Concurrent checks on the charging-port controller's pin-side outputs.
// Assumes one aclk domain and the synchronous active-low aresetn.
`timescale 1ns/1ps
module charging_ctrl_assertions
    import charging_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load_above_threshold,
    input charging_ctrl_pkg::mode_t charge_mode,
    input wire logic port_enable,
    input wire logic port_discharge,
    input wire logic data_switch_on,
    input wire logic sel_high_current_limit,
    input wire logic sel_low_current_limit,
    input wire logic sel_power_wake_internal_limit,
    input wire logic load_present_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_dis;
        charge_mode == MODE_DISCHARGE && $past(charge_mode) == MODE_DISCHARGE
            |-> !port_enable && load_present_n;
    endproperty
    a_dis: assert property (p_dis) else $error("port live in discharge mode");
    property p_inv;
        port_discharge == !port_enable
            && ($past(aresetn) || (port_discharge && load_present_n));
    endproperty
    a_inv: assert property (p_inv) else $error("discharge not inverse of enable");
    property p_seam;
        charge_mode inside {MODE_CDP, MODE_DATA_B} && $past(charge_mode) != charge_mode
            && $past(charge_mode) inside {MODE_CDP, MODE_DATA_B} |-> port_enable;
    endproperty
    a_seam: assert property (p_seam) else $error("port dropped between 1110 and 1111");
    property p_cdp;
        (charge_mode == MODE_CDP && load_above_threshold)[*6] |-> !load_present_n;
    endproperty
    a_cdp: assert property (p_cdp) else $error("load flag missing in downstream mode");
    property p_det;
        (charge_mode == MODE_AUTO_DETECT && !load_above_threshold)[*6] |-> load_present_n;
    endproperty
    a_det: assert property (p_det) else $error("load flag without load");
    property p_datab;
        charge_mode == MODE_DATA_B && $past(charge_mode) == MODE_DATA_B && port_enable
            |-> sel_low_current_limit && !sel_high_current_limit && data_switch_on;
    endproperty
    a_datab: assert property (p_datab) else $error("second data mode setup wrong");
    property p_auto;
        charge_mode == MODE_AUTO && $past(charge_mode) == MODE_AUTO && port_enable
            |-> sel_high_current_limit && !data_switch_on && load_present_n;
    endproperty
    a_auto: assert property (p_auto) else $error("auto charging setup wrong");
    property p_pwlow;
        sel_power_wake_internal_limit |-> load_present_n && !sel_high_current_limit;
    endproperty
    a_pwlow: assert property (p_pwlow) else $error("low power state outputs wrong");
    property p_pwdchg;
        $fell(port_enable) && $past(sel_power_wake_internal_limit)
            |-> (!port_enable && !load_present_n)[*8] ##[1:30] port_enable;
    endproperty
    a_pwdchg: assert property (p_pwdchg) else $error("wake discharge wrong");
    c_pw: cover property (sel_power_wake_internal_limit);
    c_cdp: cover property (charge_mode == MODE_CDP && !load_present_n);
    c_back: cover property ($rose(port_enable) && charge_mode == MODE_AUTO_PW);
endmodule

bind charging_mode_load_detect_ctrl charging_ctrl_assertions charging_ctrl_assertions_i (.*);

// ===== bench/host_ctrl_model.sv
// Host system controller that sets the mode pins and input-device flag.
// Assumes callers run in the bench's aclk domain.
`timescale 1ns/1ps
module host_ctrl_model (
    input wire logic aclk,
    output logic mode_pin_a,
    output logic mode_pin_b,
    output logic mode_pin_c,
    output logic limit_select,
    output logic input_device_seen
);
    initial begin
        {mode_pin_a, mode_pin_b, mode_pin_c, limit_select} = 4'h0;
        input_device_seen = 1'b0;
    end
    task set_pins(input logic [3:0] p);
        @(posedge aclk);
        {mode_pin_a, mode_pin_b, mode_pin_c, limit_select} <= p;
    endtask
    task set_hid(input logic v);
        @(posedge aclk);
        input_device_seen <= v;
    endtask
endmodule

// ===== bench/charging_mode_load_detect_ctrl_tb.sv
// Self-checking bench: mode table, discharge lengths, power wake, hold.
// Assumes shortened count parameters; AXI4-Lite master tasks below.
`timescale 1ns/1ps
module charging_mode_load_detect_ctrl_tb;
    import charging_ctrl_pkg::*;
    localparam int L = 12;
    localparam int S = 8;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [2:0] s_axi_awprot = 3'h0;
    logic [2:0] s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb;
    logic mode_pin_a, mode_pin_b, mode_pin_c, limit_select, input_device_seen;
    logic load_above_threshold, primary_detect_done, load_below_wake_level, at_wake_limit;
    mode_t charge_mode;
    logic port_enable, port_discharge, data_switch_on, sel_high_current_limit;
    logic sel_low_current_limit, sel_power_wake_internal_limit, load_present_n;
    int errors, n_tests, n;
    wire [4:0] outs = {port_enable, data_switch_on, sel_high_current_limit,
        sel_low_current_limit, load_present_n};
    mode_t tm [16] = '{MODE_DISCHARGE, MODE_DISCHARGE, MODE_AUTO, MODE_AUTO_PW, MODE_DATA_A,
        MODE_DATA_A, MODE_AUTO, MODE_AUTO_DETECT, MODE_SHORTED, MODE_SHORTED, MODE_DIVIDER,
        MODE_DIVIDER, MODE_DATA_A, MODE_DATA_A, MODE_DATA_B, MODE_CDP};
    logic [4:0] te [16] = '{5'h01, 5'h01, 5'h15, 5'h14, 5'h1B, 5'h1D, 5'h15, 5'h15,
        5'h13, 5'h15, 5'h13, 5'h15, 5'h1B, 5'h1D, 5'h1B, 5'h1D};
    // Data line state in forced charging modes is left unchecked
    logic [4:0] tk [16] = '{5'h19, 5'h19, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F,
        5'h17, 5'h17, 5'h17, 5'h17, 5'h1F, 5'h1F, 5'h1F, 5'h1F};

    host_ctrl_model host_ctrl_model_i (.*);
    charging_mode_load_detect_ctrl #(.PW_IDLE_CNT(20), .PW_DCHG_CNT(16), .DCHG_LONG_CNT(L),
        .DCHG_SHORT_CNT(S)) charging_mode_load_detect_ctrl_i (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task wt(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        tb = 1'b0;
        while (!tb) begin
            @(negedge aclk);
            {ta, tw, tb, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            s_axi_awvalid <= s_axi_awvalid & ~ta;
            s_axi_wvalid <= s_axi_wvalid & ~tw;
        end
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta, tr;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        tr = 1'b0;
        while (!tr) begin
            @(negedge aclk);
            {ta, tr, v, rs} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            s_axi_arvalid <= s_axi_arvalid & ~ta;
        end
        s_axi_rready <= 1'b0;
    endtask
    // Length of the next port-off stretch, in cycles
    task meas();
        n = 0;
        while (port_enable && n < 200) begin
            wt(1);
            n++;
        end
        n = 0;
        while (!port_enable && n < 400) begin
            wt(1);
            n++;
        end
    endtask
    task end_sim();
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hF;
        {load_above_threshold, primary_detect_done} = 2'h0;
        {load_below_wake_level, at_wake_limit} = 2'h0;
        wt(6);
        aresetn <= 1'b1;
        wt(3);
        chk("init_port", 0, port_enable);
        rd(CTRL_OFFSET, d, r);
        chk("ctrl", 32'h1, d);
        rd(12'h010, d, r);
        chk("rresp", RESP_SLVERR, r);
        for (int i = 0; i < 16; i++) begin
            host_ctrl_model_i.set_pins(i[3:0]);
            wt(40);
            chk("mode", tm[i], charge_mode);
            chk("outs", te[i] & tk[i], outs & tk[i]);
            if (i == 7 || i == 15) begin
                load_above_threshold <= 1'b1;
                wt(8);
                chk("load", 0, load_present_n);
                load_above_threshold <= 1'b0;
                primary_detect_done <= i[3];
                wt(8);
                chk("prim", !i[3], load_present_n);
            end
        end
        primary_detect_done <= 1'b0;
        host_ctrl_model_i.set_pins(4'h3);
        meas();
        chk("long", 1, n >= L - 1 && n <= L + 2);
        load_below_wake_level <= 1'b1;
        wt(40);
        chk("pw_low", 3'h5, {sel_power_wake_internal_limit, outs[2], outs[0]});
        load_below_wake_level <= 1'b0;
        at_wake_limit <= 1'b1;
        wt(6);
        chk("pw_wake", 0, {port_enable, load_present_n});
        at_wake_limit <= 1'b0;
        wt(30);
        chk("pw_back", 3'h6, {outs[4], outs[2], sel_power_wake_internal_limit});
        host_ctrl_model_i.set_pins(4'hF);
        meas();
        chk("short", 1, n >= S - 1 && n <= S + 2);
        wt(10);
        host_ctrl_model_i.set_hid(1'b1);
        host_ctrl_model_i.set_pins(4'h6);
        wt(40);
        chk("hold", 2'h3, outs[4:3]);
        rd(STATUS_OFFSET, d, r);
        chk("st_hold", 1, d[ST_HOLD_BIT]);
        // Byte lane 0 off: control bit must keep its value
        s_axi_wstrb <= 4'h0;
        wr(CTRL_OFFSET, 32'h0, r);
        rd(CTRL_OFFSET, d, r);
        chk("strb", 32'h1, d);
        s_axi_wstrb <= 4'hF;
        wr(CTRL_OFFSET, 32'h0, r);
        chk("bresp", RESP_OKAY, r);
        wt(40);
        chk("released", MODE_AUTO, charge_mode);
        rd(STATUS_OFFSET, d, r);
        chk("st_mode", {1'b0, MODE_AUTO}, d[4:0]);
        wr(12'h020, 32'h1, r);
        chk("bresp_bad", RESP_SLVERR, r);
        aresetn <= 1'b0;
        wt(4);
        chk("rst", 3'h3, {port_enable, port_discharge, load_present_n});
        aresetn <= 1'b1;
        wt(4);
        chk("rst_init", 0, port_enable);
        end_sim();
    end
    initial begin
        wt(20000);
        errors++;
        end_sim();
    end
endmodule
